/* bench/wcthr_top_sva.sv */
// Purpose: Port checks for wcthr_top
// Assumes: One clock, synchronous active-low reset
// Notes: Sees only top ports; bound from the bench top
`timescale 1ns/1ps
`default_nettype none
module wcthr_top_sva (
  input wire ref_clk_i,
  input wire nrst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire sample_valid_i,
  input wire sample_chan_i,
  input wire [1:0] tripped_o,
  input wire irq_o
);
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  ack_answer_a: assert property (req |=> wb_ack_o)
    else $error("request not acked");
  ack_cause_a: assert property (wb_ack_o |-> $past(req))
    else $error("ack without request");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  rdata_hold_a: assert property ($changed(wb_dat_o) |-> $past(req && !wb_we_i))
    else $error("read data moved without read");
  trip_one_a: assert property ($changed(tripped_o[0]) |->
    $past(sample_valid_i && !sample_chan_i)) else $error("ch1 moved without sample");
  trip_two_a: assert property ($changed(tripped_o[1]) |->
    $past(sample_valid_i && sample_chan_i)) else $error("ch2 moved without sample");
  irq_fall_a: assert property ($fell(irq_o) |-> $past(wb_we_i && wb_ack_o))
    else $error("irq dropped without write");
  irq_rise_a: assert property ($rose(irq_o) |->
    $past(wb_we_i && wb_ack_o) || $past(tripped_o) != 2'h0) else $error("irq rose without cause");
  rst_clear_a: assert property (disable iff (1'h0)
    !nrst_i |=> !wb_ack_o && !irq_o && tripped_o == 2'h0) else $error("reset left outputs set");
endmodule // wcthr_top_sva
`default_nettype wire

/* bench/wcthr_top_tb.sv */
// Purpose: Self-checking bench for wcthr_top
// Assumes: Byte address is register index times four
// Notes: Scenarios run in order; region, digital and flag state carry over from earlier ones
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin num_errors++; \
  $display("[ERR] %0t got %0h exp %0h", $time, (a), (b)); end end
module wcthr_top_tb;
  logic ref_clk_i = 1'h0;
  logic nrst_i = 1'h0;
  logic wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic sample_valid_i = 1'h0, sample_chan_i = 1'h0;
  logic [11:0] sample_data_i = 12'h000;
  wire [31:0] wb_dat_o;
  wire wb_ack_o, irq_o;
  wire [1:0] tripped_o;
  logic [31:0] rd;
  logic [5:0] k;
  int num_errors = 0, compares = 0;
  always #10 ref_clk_i = ~ref_clk_i;
  wcthr_top i_dut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .sample_valid_i(sample_valid_i), .sample_chan_i(sample_chan_i),
    .sample_data_i(sample_data_i), .tripped_o(tripped_o), .irq_o(irq_o));
  task automatic finish_test;
    if (num_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Request held until ack is sampled; bounded wait
  task automatic wb(input logic we, input logic [5:0] x, input logic [7:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= {x, 2'h0};
    wb_sel_i <= s;
    wb_dat_i <= {24'h0, d};
    do begin @(posedge ref_clk_i); n++; end while (wb_ack_o !== 1'h1 && n < 20);
    if (wb_ack_o !== 1'h1) begin num_errors++; finish_test; end
    rd = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    wb_we_i <= 1'h0;
  endtask
  task automatic wr(input logic [5:0] x, input logic [7:0] d);
    wb(1'h1, x, d, 4'hF);
  endtask
  task automatic rdc(input logic [5:0] x, input logic [7:0] e);
    wb(1'h0, x, 8'h00, 4'hF);
    `CHK(rd, {24'h0, e})
  endtask
  task automatic cfg(input logic [5:0] x, input logic [7:0] h, hi, c, lo);
    wr(x, h);
    wr(x + 6'h1, hi);
    wr(x + 6'h2, c);
    wr(x + 6'h3, lo);
  endtask
  task automatic smp(input logic ch, input logic [11:0] d, input logic e);
    @(posedge ref_clk_i);
    sample_valid_i <= 1'h1;
    sample_chan_i <= ch;
    sample_data_i <= d;
    @(posedge ref_clk_i);
    sample_valid_i <= 1'h0;
    #1 `CHK(tripped_o[ch], e)
  endtask
  task automatic irq_chk(input logic e);
    @(posedge ref_clk_i);
    #1 `CHK(irq_o, e)
  endtask
  function automatic logic [7:0] rv(input logic [1:0] s);
    return s == 2'h0 ? 8'hF0 : s == 2'h1 ? 8'hFF : 8'h00;
  endfunction
  task automatic t_regs;
    for (k = 6'h24; k < 6'h2C; k++) rdc(k, rv(k[1:0]));
    for (k = 6'h24; k < 6'h2C; k++) wr(k, {2'h2, k});
    for (k = 6'h24; k < 6'h2C; k++) rdc(k, {2'h2, k});
    wr(6'h3F, 8'hA5);
    rdc(6'h3F, 8'h00);
    wb(1'h1, 6'h24, 8'h11, 4'hE);
    rdc(6'h24, 8'hA4);
  endtask
  task automatic t_thr;
    cfg(6'h24, 8'h30, 8'h12, 8'h00, 8'h00);
    wr(6'h31, 8'h01);
    smp(1'h0, 12'h123, 1'h0);
    smp(1'h0, 12'h124, 1'h1);
    irq_chk(1'h1);
    wr(6'h24, 8'h32);
    smp(1'h0, 12'h114, 1'h1);
    smp(1'h0, 12'h113, 1'h0);
    wr(6'h30, 8'h00);
    rdc(6'h30, 8'h01);
    wr(6'h30, 8'h01);
    rdc(6'h30, 8'h00);
    cfg(6'h24, 8'hF0, 8'hFF, 8'h50, 8'h0A);
    smp(1'h0, 12'h0A5, 1'h0);
    smp(1'h0, 12'h0A4, 1'h1);
    wr(6'h24, 8'hF1);
    smp(1'h0, 12'h0AC, 1'h1);
    smp(1'h0, 12'h0AD, 1'h0);
    wr(6'h31, 8'h00);
    irq_chk(1'h0);
    wr(6'h31, 8'h01);
    irq_chk(1'h1);
    wr(6'h30, 8'h01);
    irq_chk(1'h0);
  endtask
  // Run broken after two beyond samples restarts the count
  task automatic t_count;
    cfg(6'h28, 8'h30, 8'h12, 8'h02, 8'h00);
    smp(1'h1, 12'h124, 1'h0);
    smp(1'h1, 12'h124, 1'h0);
    smp(1'h1, 12'h100, 1'h0);
    smp(1'h1, 12'h124, 1'h0);
    smp(1'h1, 12'h124, 1'h0);
    smp(1'h1, 12'h124, 1'h1);
    wr(6'h31, 8'h02);
    rdc(6'h30, 8'h02);
    irq_chk(1'h1);
  endtask
  task automatic t_region;
    cfg(6'h24, 8'h00, 8'h20, 8'h00, 8'h10);
    wr(6'h32, 8'h01);
    smp(1'h0, 12'h150, 1'h1);
    smp(1'h0, 12'h250, 1'h0);
    wr(6'h32, 8'h00);
    wr(6'h33, 8'h01);
    smp(1'h0, 12'h001, 1'h1);
    smp(1'h0, 12'hFFE, 1'h0);
    wr(6'h32, 8'h01);
    smp(1'h0, 12'hFFE, 1'h1);
    smp(1'h0, 12'h001, 1'h0);
  endtask
  // Mid-run reset while channel 2 is tripped and its flag drives irq
  task automatic t_reset;
    @(posedge ref_clk_i);
    nrst_i <= 1'h0;
    repeat (5) @(posedge ref_clk_i);
    nrst_i <= 1'h1;
    #1 `CHK(tripped_o, 2'h0)
    `CHK(irq_o, 1'h0)
    rdc(6'h24, 8'hF0);
    rdc(6'h25, 8'hFF);
    rdc(6'h26, 8'h00);
    rdc(6'h27, 8'h00);
    rdc(6'h28, 8'hF0);
    rdc(6'h29, 8'hFF);
    rdc(6'h2A, 8'h00);
    rdc(6'h30, 8'h00);
    rdc(6'h32, 8'h00);
  endtask
  initial begin
    repeat (5) @(posedge ref_clk_i);
    nrst_i <= 1'h1;
    t_regs;
    t_thr;
    t_count;
    t_region;
    t_reset;
    finish_test;
  end
endmodule // wcthr_top_tb
bind wcthr_top wcthr_top_sva i_sva (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .sample_valid_i(sample_valid_i), .sample_chan_i(sample_chan_i),
  .tripped_o(tripped_o), .irq_o(irq_o));
`default_nettype wire

/* common/wcthr_defines.vh */
// Purpose: Constants for the window comparator threshold register bank
// Assumes: Register indexes; byte address on the bus is four times the index
// Notes: Included by every design file of the block
`ifndef WCTHR_DEFINES_VH
`define WCTHR_DEFINES_VH

`define WCTHR_IDX_CH1_HYST 6'h24
`define WCTHR_IDX_CH1_HIGH 6'h25
`define WCTHR_IDX_CH1_CNT 6'h26
`define WCTHR_IDX_CH1_LOW 6'h27
`define WCTHR_IDX_CH2_HYST 6'h28
`define WCTHR_IDX_CH2_HIGH 6'h29
`define WCTHR_IDX_CH2_CNT 6'h2A
`define WCTHR_IDX_CH2_LOW 6'h2B
`define WCTHR_CH_STRIDE 6'h04
`define WCTHR_SLOT_HYST 6'h00
`define WCTHR_SLOT_HIGH 6'h01
`define WCTHR_SLOT_CNT 6'h02
`define WCTHR_SLOT_LOW 6'h03
`define WCTHR_IDX_STATUS 6'h30
`define WCTHR_IDX_MASK 6'h31
`define WCTHR_IDX_REGION 6'h32
`define WCTHR_IDX_DIGITAL 6'h33

`define WCTHR_RST_HYST 8'hF0
`define WCTHR_RST_HIGH 8'hFF
`define WCTHR_RST_CNT 8'h00
`define WCTHR_RST_LOW 8'h00
`define WCTHR_RST_CTRL 2'h0

`define WCTHR_NIB_UP 7:4
`define WCTHR_NIB_DN 3:0
`define WCTHR_HYST_SHIFT 3
`define WCTHR_NCH 2

`endif

/* src/wcthr_cmp.v */
// Purpose: Beyond-threshold test for one channel and one sample
// Assumes: Thresholds and result are unsigned 12-bit values
// Notes: Pure combinational; the caller holds the tripped state
`timescale 1ns/1ps
`default_nettype none
`include "wcthr_defines.vh"
module wcthr_cmp (
  input wire [11:0] result_i,
  input wire [11:0] high_i,
  input wire [11:0] low_i,
  input wire [3:0] hyst_i,
  input wire region_i,
  input wire digital_i,
  input wire tripped_i,
  output reg beyond_o
);
  wire [6:0] amt;
  wire [12:0] res_x;
  wire [12:0] res_h;
  wire [12:0] high_x;
  wire [12:0] high_h;
  wire [12:0] low_x;
  wire [12:0] low_h;
  assign amt = {hyst_i, 3'h0};
  // Adding on both sides avoids any underflow of threshold minus hysteresis
  assign res_x = {1'b0, result_i};
  assign res_h = res_x + {6'h00, amt};
  assign high_x = {1'b0, high_i};
  assign high_h = high_x + {6'h00, amt};
  assign low_x = {1'b0, low_i};
  assign low_h = low_x + {6'h00, amt};
  always @* begin
    beyond_o = 1'b0;
    if (digital_i) begin
      beyond_o = region_i ? ~result_i[0] : result_i[0];
    end else if (!region_i) begin
      if (tripped_i) begin
        beyond_o = (res_h > high_x) || (res_x < low_h);
      end else begin
        beyond_o = (res_x > high_x) || (res_x < low_x);
      end
    end else begin
      if (tripped_i) begin
        beyond_o = (res_h > low_x) && (res_x < high_h);
      end else begin
        beyond_o = (res_x > low_x) && (res_x < high_x);
      end
    end
  end
endmodule // wcthr_cmp
`default_nettype wire

/* src/wcthr_flags.v */
// Purpose: Sticky event flags, mask gating and interrupt level
// Assumes: Set and clear are one-cycle pulses
// Notes: A set in the clearing cycle wins
`timescale 1ns/1ps
`default_nettype none
`include "wcthr_defines.vh"
module wcthr_flags (
  input wire ref_clk_i,
  input wire nrst_i,
  input wire [1:0] set_i,
  input wire [1:0] clr_i,
  input wire [1:0] mask_i,
  output reg [1:0] status_o,
  output wire irq_o
);
  wire [1:0] next_status;
  assign next_status = (status_o & ~clr_i) | set_i;
  always @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      status_o <= 2'h0;
    end else begin
      status_o <= next_status;
    end
  end
  assign irq_o = |(status_o & mask_i);
endmodule // wcthr_flags
`default_nettype wire

/* src/wcthr_top.v */
// Purpose: Threshold, hysteresis and count registers for two comparator channels
// Assumes: Classic Wishbone slave, 32-bit data, index times four is byte address
// Notes: Samples arrive tagged with their channel, one per valid pulse
//
// Register access over Wishbone is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "wcthr_defines.vh"
module wcthr_top (
  input wire ref_clk_i,
  input wire nrst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire sample_valid_i,
  input wire sample_chan_i,
  input wire [11:0] sample_data_i,
  output wire [1:0] tripped_o,
  output wire irq_o
);
  integer i;
  // Separate loop variable so the read mux and the write process never share a driver
  integer j;

  // Register index of a slot inside a channel group
  function [5:0] reg_index;
    input integer ch;
    input [5:0] slot;
    reg [31:0] t;
    begin
      t = `WCTHR_IDX_CH1_HYST + ch * `WCTHR_CH_STRIDE + slot;
      reg_index = t[5:0];
    end
  endfunction

  reg [7:0] hyst_reg [0:1];
  reg [7:0] high_reg [0:1];
  reg [7:0] cnt_reg [0:1];
  reg [7:0] low_reg [0:1];
  reg [1:0] mask_reg;
  reg [1:0] region_reg;
  reg [1:0] digital_reg;

  wire [1:0] status;
  wire [1:0] evt_set;
  wire [1:0] evt_clr;
  wire [5:0] idx;
  wire bus_req;
  wire wr_go;
  reg [31:0] next_rdata;

  assign idx = wb_adr_i[7:2];
  assign bus_req = wb_cyc_i & wb_stb_i;
  // Writes land at the edge where the master sees ack
  assign wr_go = bus_req & wb_we_i & wb_ack_o & wb_sel_i[0];

  always @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req & ~wb_ack_o;
    end
  end

  always @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      for (i = 0; i < `WCTHR_NCH; i = i + 1) begin
        hyst_reg[i] <= `WCTHR_RST_HYST;
        high_reg[i] <= `WCTHR_RST_HIGH;
        cnt_reg[i] <= `WCTHR_RST_CNT;
        low_reg[i] <= `WCTHR_RST_LOW;
      end
    end else if (wr_go) begin
      for (i = 0; i < `WCTHR_NCH; i = i + 1) begin
        if (idx == reg_index(i, `WCTHR_SLOT_HYST)) begin
          hyst_reg[i] <= wb_dat_i[7:0];
        end
        if (idx == reg_index(i, `WCTHR_SLOT_HIGH)) begin
          high_reg[i] <= wb_dat_i[7:0];
        end
        if (idx == reg_index(i, `WCTHR_SLOT_CNT)) begin
          cnt_reg[i] <= wb_dat_i[7:0];
        end
        if (idx == reg_index(i, `WCTHR_SLOT_LOW)) begin
          low_reg[i] <= wb_dat_i[7:0];
        end
      end
    end
  end

  always @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      mask_reg <= `WCTHR_RST_CTRL;
      region_reg <= `WCTHR_RST_CTRL;
      digital_reg <= `WCTHR_RST_CTRL;
    end else if (wr_go) begin
      if (idx == `WCTHR_IDX_MASK) begin
        mask_reg <= wb_dat_i[1:0];
      end
      if (idx == `WCTHR_IDX_REGION) begin
        region_reg <= wb_dat_i[1:0];
      end
      if (idx == `WCTHR_IDX_DIGITAL) begin
        digital_reg <= wb_dat_i[1:0];
      end
    end
  end

  // Only a written one clears; the flag bank lets a set win
  assign evt_clr = (wr_go && idx == `WCTHR_IDX_STATUS) ? wb_dat_i[1:0] : 2'h0;

  always @* begin
    next_rdata = 32'h00000000;
    for (j = 0; j < `WCTHR_NCH; j = j + 1) begin
      if (idx == reg_index(j, `WCTHR_SLOT_HYST)) begin
        next_rdata = {24'h000000, hyst_reg[j]};
      end
      if (idx == reg_index(j, `WCTHR_SLOT_HIGH)) begin
        next_rdata = {24'h000000, high_reg[j]};
      end
      if (idx == reg_index(j, `WCTHR_SLOT_CNT)) begin
        next_rdata = {24'h000000, cnt_reg[j]};
      end
      if (idx == reg_index(j, `WCTHR_SLOT_LOW)) begin
        next_rdata = {24'h000000, low_reg[j]};
      end
    end
    case (idx)
      `WCTHR_IDX_STATUS: begin
        next_rdata = {30'h0, status};
      end
      `WCTHR_IDX_MASK: begin
        next_rdata = {30'h0, mask_reg};
      end
      `WCTHR_IDX_REGION: begin
        next_rdata = {30'h0, region_reg};
      end
      `WCTHR_IDX_DIGITAL: begin
        next_rdata = {30'h0, digital_reg};
      end
      default: begin
        next_rdata = next_rdata;
      end
    endcase
  end

  // Unmapped reads still get ack, with zero data
  always @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      wb_dat_o <= 32'h00000000;
    end else if (bus_req & ~wb_ack_o & ~wb_we_i) begin
      wb_dat_o <= next_rdata;
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < `WCTHR_NCH; ch = ch + 1) begin : g_chan
      wire [11:0] high_full;
      wire [11:0] low_full;
      wire beyond;
      wire hit;
      reg [3:0] run_cnt;
      reg tripped;
      reg set_pulse;

      assign high_full = {high_reg[ch], hyst_reg[ch][`WCTHR_NIB_UP]};
      assign low_full = {low_reg[ch], cnt_reg[ch][`WCTHR_NIB_UP]};
      assign hit = sample_valid_i && (sample_chan_i == ch);

      wcthr_cmp u_cmp (
        .result_i(sample_data_i),
        .high_i(high_full),
        .low_i(low_full),
        .hyst_i(hyst_reg[ch][`WCTHR_NIB_DN]),
        .region_i(region_reg[ch]),
        .digital_i(digital_reg[ch]),
        .tripped_i(tripped),
        .beyond_o(beyond)
      );

      // Pulse only on entry, so a cleared flag is not re-set while held
      always @(posedge ref_clk_i) begin
        if (!nrst_i) begin
          run_cnt <= 4'h0;
          tripped <= 1'b0;
          set_pulse <= 1'b0;
        end else begin
          set_pulse <= 1'b0;
          if (hit) begin
            if (!beyond) begin
              run_cnt <= 4'h0;
              tripped <= 1'b0;
            end else if (!tripped) begin
              if (run_cnt == cnt_reg[ch][`WCTHR_NIB_DN]) begin
                tripped <= 1'b1;
                set_pulse <= 1'b1;
                run_cnt <= 4'h0;
              end else begin
                run_cnt <= run_cnt + 4'h1;
              end
            end
          end
        end
      end

      assign evt_set[ch] = set_pulse;
      assign tripped_o[ch] = tripped;
    end
  endgenerate

  wcthr_flags u_flags (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .set_i(evt_set),
    .clr_i(evt_clr),
    .mask_i(mask_reg),
    .status_o(status),
    .irq_o(irq_o)
  );
endmodule // wcthr_top
`default_nettype wire
